// >>> sfr_pkg.sv
// Behaviour
// - each read sends command, then address, then dummy cycles, then reads data
// - with idle_clock_level clear, serial clock stays low while select is negated
// - with transmit_edge_select clear, outgoing SDR bits change on even clock edges
// - with receive_edge_select set, SDR data is sampled on even edges (falling when idle_clock_level is clear)
// - first bit, msb first, is presented before the first rising edge
// - device_count_field 00 selects one flash, 01 selects two in parallel
// - address and data width fields 00 select one line, 10 four lines; default four-line SDR
// - address_enable_field 0111 sends three address bytes, 1111 sends four
// - ddr enables clear run address/data SDR, set run them double data rate
// - command phase sends the 8-bit read_command_code, reset value ec
// - programmed dummy cycles sit between address and data; default field 001
// - any read command code, such as 0b, 0c, eb or ec, can be issued
package sfr_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_COMMON = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_DUMMY = 8'h10;
  localparam logic [7:0] OFS_ADDR = 8'h14;
  localparam logic [7:0] OFS_START = 8'h18;
  localparam logic [7:0] OFS_DATA = 8'h1c;
  // reset values and writable-bit masks
  localparam logic [31:0] RST_COMMON = 32'h0000_0004;
  localparam logic [31:0] RST_ENABLE = 32'h0000_0f2a;
  localparam logic [31:0] RST_RATE = 32'h0000_0000;
  localparam logic [31:0] RST_CMD = 32'h0000_00ec;
  localparam logic [31:0] RST_DUMMY = 32'h0000_0001;
  localparam logic [31:0] MSK_COMMON = 32'h0000_0037;
  localparam logic [31:0] MSK_ENABLE = 32'h0000_0f3f;
  localparam logic [31:0] MSK_RATE = 32'h0000_0007;
  localparam logic [31:0] MSK_CMD = 32'h0000_00ff;
  localparam logic [31:0] MSK_DUMMY = 32'h0000_0007;
  // field positions
  localparam int CC_IDLE_CLOCK_LEVEL = 0;
  localparam int CC_TRANSMIT_EDGE_SELECT = 1;
  localparam int CC_RECEIVE_EDGE_SELECT = 2;
  localparam int CC_BSZ = 4;
  localparam int RE_ADB = 0;
  localparam int RE_OPTION_WIDTH_FIELD = 2;
  localparam int RE_READ_DATA_WIDTH_FIELD = 4;
  localparam int RE_ADE = 8;
  localparam int RR_ADDR = 0;
  localparam int RR_OPT = 1;
  localparam int RR_DATA = 2;
  localparam int SR_BUSY = 0;
  localparam int SR_DONE = 1;
  // field encodings
  localparam logic [1:0] BSZ_DUAL = 2'h1;
  localparam logic [1:0] WID_QUAD = 2'h2;
  localparam logic [3:0] ADE_4B = 4'hf;
  // counts
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [5:0] DATA_BITS = 6'h20;
  localparam logic [5:0] DMY_BASE = 6'h03;
  localparam int HALF_CYC = 6;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {S_IDLE, S_CMD, S_ADDR, S_DUMMY, S_DATA, S_TAIL} sfr_state_e;
endpackage

// >>> sfr_edge_gen.sv
module sfr_edge_gen #(
  parameter int HALF = sfr_pkg::HALF_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic run_i,
  output logic edge_o
);
  import sfr_pkg::*;

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;

  // restarts from zero each frame so the first edge keeps a full half period of setup
  always_comb begin
    nxt_cnt = 8'h00;
    if (run_i && cnt_ff != 8'(HALF - 1)) begin
      nxt_cnt = 8'(cnt_ff + 8'h01);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign edge_o = run_i && (cnt_ff == 8'(HALF - 1));
endmodule

// >>> sfr_in_sync.sv
module sfr_in_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // pin side and filtered side
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] filt_o
);
  import sfr_pkg::*;

  logic [W-1:0] s1_ff, s2_ff, s3_ff, filt_ff;
  logic [W-1:0] nxt_filt;

  // a change counts only once stages two and three agree
  always_comb begin
    nxt_filt = filt_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_filt[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      filt_ff <= '0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  assign filt_o = filt_ff;
endmodule

// >>> sfr_read_seq.sv
// Local design decisions: the address map and register access over AXI4-Lite.
module sfr_read_seq #(
  parameter int HALF = sfr_pkg::HALF_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // flash pins
  output logic serial_clock_pin_o,
  output logic slave_select_pin_b_o,
  output logic [7:0] io_out_o,
  output logic [7:0] io_oe_o,
  input wire logic [7:0] io_in_i
);
  import sfr_pkg::*;

  // bus-side state
  logic [31:0] common_control_reg_ff, read_enable_reg_ff, read_rate_enable_reg_ff;
  logic [31:0] read_command_reg_ff, read_dummy_reg_ff, read_address_reg_ff;
  logic [31:0] nxt_common, nxt_enable, nxt_rate, nxt_cmd, nxt_dummy, nxt_addr;
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff, start_ff;
  logic nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid, nxt_start;
  logic [7:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data, rdata_ff, nxt_rdata;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;

  // sequencer state
  sfr_state_e state_ff, nxt_state;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [31:0] sh_ff, nxt_sh, rx_ff, nxt_rx, data_ff, nxt_data;
  logic primed_ff, odd_ff, sclk_ff, ssl_b_ff, done_ff;
  logic nxt_primed, nxt_odd, nxt_sclk, nxt_ssl_b, nxt_done;
  logic [7:0] out_ff, oe_ff, nxt_out, nxt_oe;

  // decoded configuration
  logic idle_clock_level, transmit_edge_select, receive_edge_select, dual, quad_a, quad_d, four_b, ddr_a, ddr_d;
  logic [5:0] addr_bits, addr_slots, data_samples, dummy_cyc;
  logic [2:0] dsh;
  logic busy, edge_w, launch, sample;
  logic [7:0] io_filt;
  logic [3:0] lanes, lane_oe;
  logic [31:0] rx_shift;

  assign idle_clock_level = common_control_reg_ff[CC_IDLE_CLOCK_LEVEL];
  assign transmit_edge_select = common_control_reg_ff[CC_TRANSMIT_EDGE_SELECT];
  assign receive_edge_select = common_control_reg_ff[CC_RECEIVE_EDGE_SELECT];
  assign dual = common_control_reg_ff[CC_BSZ+:2] == BSZ_DUAL;
  assign quad_a = read_enable_reg_ff[RE_ADB+:2] == WID_QUAD;
  assign quad_d = read_enable_reg_ff[RE_READ_DATA_WIDTH_FIELD+:2] == WID_QUAD;
  assign four_b = read_enable_reg_ff[RE_ADE+:4] == ADE_4B;
  assign ddr_a = read_rate_enable_reg_ff[RR_ADDR];
  assign ddr_d = read_rate_enable_reg_ff[RR_DATA];
  assign addr_bits = four_b ? ADDR4_BITS : ADDR3_BITS;
  assign addr_slots = quad_a ? (addr_bits >> 2) : addr_bits;
  assign dsh = (quad_d ? 3'h2 : 3'h0) + {2'h0, dual};
  assign data_samples = DATA_BITS >> dsh;
  assign dummy_cyc = {3'h0, read_dummy_reg_ff[2:0]} + DMY_BASE;
  assign busy = (state_ff != S_IDLE) || start_ff;

  sfr_edge_gen #(.HALF(HALF)) u_edge (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(state_ff != S_IDLE),
    .edge_o(edge_w)
  );

  sfr_in_sync #(.W(8)) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(io_in_i),
    .filt_o(io_filt)
  );

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i+:8] = nw[8*i+:8];
      end
    end
    return r & msk;
  endfunction

  // bus handshakes; one write and one read in flight
  assign s_axi_awready_o = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready_o = !w_got_ff && !bvalid_ff;
  assign s_axi_arready_o = !rvalid_ff;

  // bus next state; config is frozen while a read runs to avoid mid-frame changes
  always_comb begin
    nxt_common = common_control_reg_ff;
    nxt_enable = read_enable_reg_ff;
    nxt_rate = read_rate_enable_reg_ff;
    nxt_cmd = read_command_reg_ff;
    nxt_dummy = read_dummy_reg_ff;
    nxt_addr = read_address_reg_ff;
    nxt_aw_got = aw_got_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_got = w_got_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    nxt_start = 1'b0;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      nxt_aw_got = 1'b1;
      nxt_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      nxt_w_got = 1'b1;
      nxt_w_data = s_axi_wdata_i;
      nxt_w_strb = s_axi_wstrb_i;
    end
    if (bvalid_ff && s_axi_bready_i) begin
      nxt_bvalid = 1'b0;
    end
    if (aw_got_ff && w_got_ff) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      unique case (aw_addr_ff)
        OFS_COMMON: if (!busy) nxt_common = merge(common_control_reg_ff, w_data_ff, w_strb_ff,
                                                  MSK_COMMON);
        OFS_ENABLE: if (!busy) nxt_enable = merge(read_enable_reg_ff, w_data_ff, w_strb_ff,
                                                  MSK_ENABLE);
        OFS_RATE: if (!busy) nxt_rate = merge(read_rate_enable_reg_ff, w_data_ff, w_strb_ff,
                                              MSK_RATE);
        OFS_CMD: if (!busy) nxt_cmd = merge(read_command_reg_ff, w_data_ff, w_strb_ff,
                                            MSK_CMD);
        OFS_DUMMY: if (!busy) nxt_dummy = merge(read_dummy_reg_ff, w_data_ff, w_strb_ff,
                                                MSK_DUMMY);
        OFS_ADDR: if (!busy) nxt_addr = merge(read_address_reg_ff, w_data_ff, w_strb_ff,
                                              32'hffff_ffff);
        OFS_START: nxt_start = !busy && w_strb_ff[0] && w_data_ff[0];
        OFS_DATA: nxt_bresp = RESP_OKAY;
        default: nxt_bresp = RESP_SLVERR;
      endcase
    end
    if (rvalid_ff && s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      unique case (s_axi_araddr_i)
        OFS_COMMON: nxt_rdata = common_control_reg_ff;
        OFS_ENABLE: nxt_rdata = read_enable_reg_ff;
        OFS_RATE: nxt_rdata = read_rate_enable_reg_ff;
        OFS_CMD: nxt_rdata = read_command_reg_ff;
        OFS_DUMMY: nxt_rdata = read_dummy_reg_ff;
        OFS_ADDR: nxt_rdata = read_address_reg_ff;
        OFS_START: nxt_rdata = {30'h0, done_ff, busy};
        OFS_DATA: nxt_rdata = data_ff;
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      common_control_reg_ff <= RST_COMMON;
      read_enable_reg_ff <= RST_ENABLE;
      read_rate_enable_reg_ff <= RST_RATE;
      read_command_reg_ff <= RST_CMD;
      read_dummy_reg_ff <= RST_DUMMY;
      read_address_reg_ff <= 32'h0000_0000;
      aw_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_got_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      start_ff <= 1'b0;
    end else begin
      common_control_reg_ff <= nxt_common;
      read_enable_reg_ff <= nxt_enable;
      read_rate_enable_reg_ff <= nxt_rate;
      read_command_reg_ff <= nxt_cmd;
      read_dummy_reg_ff <= nxt_dummy;
      read_address_reg_ff <= nxt_addr;
      aw_got_ff <= nxt_aw_got;
      aw_addr_ff <= nxt_aw_addr;
      w_got_ff <= nxt_w_got;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      start_ff <= nxt_start;
    end
  end

  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign s_axi_rdata_o = rdata_ff;

  // edge qualification; the first edge of a frame is odd
  assign launch = edge_w && ((state_ff == S_ADDR && ddr_a) || (odd_ff == transmit_edge_select));
  // flash drives from falling edges, so even-edge sampling gives a full period
  assign sample = edge_w && (ddr_d || (odd_ff != receive_edge_select));

  // incoming lanes: one line on io1/io5, four on io3:0/io7:4
  always_comb begin
    unique case ({quad_d, dual})
      2'b00: rx_shift = {rx_ff[30:0], io_filt[1]};
      2'b01: rx_shift = {rx_ff[29:0], io_filt[1], io_filt[5]};
      2'b10: rx_shift = {rx_ff[27:0], io_filt[3:0]};
      2'b11: rx_shift = {rx_ff[23:0], io_filt[3:0], io_filt[7:4]};
    endcase
  end

  // frame sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_rx = rx_ff;
    nxt_data = data_ff;
    nxt_primed = primed_ff;
    nxt_odd = odd_ff;
    nxt_sclk = sclk_ff;
    nxt_ssl_b = ssl_b_ff;
    nxt_done = done_ff;
    if (edge_w) begin
      nxt_odd = !odd_ff;
      nxt_sclk = !sclk_ff;
    end
    unique case (state_ff)
      S_IDLE: begin
        nxt_sclk = idle_clock_level;
        nxt_ssl_b = 1'b1;
        nxt_odd = 1'b1;
        if (start_ff) begin
          nxt_state = S_CMD;
          nxt_sh = {read_command_reg_ff[7:0], 24'h00_0000};
          nxt_cnt = CMD_BITS - 6'h01;
          nxt_primed = !transmit_edge_select;
          nxt_ssl_b = 1'b0;
          nxt_done = 1'b0;
        end
      end
      S_CMD, S_ADDR: begin
        if (launch) begin
          if (!primed_ff) begin
            nxt_primed = 1'b1;
          end else if (cnt_ff != 6'h00) begin
            nxt_cnt = cnt_ff - 6'h01;
            nxt_sh = (state_ff == S_ADDR && quad_a) ? (sh_ff << 4) : (sh_ff << 1);
          end else if (state_ff == S_CMD) begin
            nxt_state = S_ADDR;
            nxt_sh = four_b ? read_address_reg_ff : {read_address_reg_ff[23:0], 8'h00};
            nxt_cnt = addr_slots - 6'h01;
          end else begin
            nxt_state = S_DUMMY;
            nxt_cnt = dummy_cyc - 6'h01;
          end
        end
      end
      S_DUMMY: begin
        if (launch) begin
          if (cnt_ff != 6'h00) begin
            nxt_cnt = cnt_ff - 6'h01;
          end else begin
            nxt_state = S_DATA;
            nxt_cnt = data_samples - 6'h01;
          end
        end
      end
      S_DATA: begin
        if (sample) begin
          nxt_rx = rx_shift;
          if (cnt_ff == 6'h00) begin
            nxt_state = S_TAIL;
          end else begin
            nxt_cnt = cnt_ff - 6'h01;
          end
        end
      end
      S_TAIL: begin
        // one more edge may be needed so the clock rests at its idle level first
        if (sclk_ff == idle_clock_level) begin
          nxt_sclk = sclk_ff;
          nxt_state = S_IDLE;
          nxt_ssl_b = 1'b1;
          nxt_done = 1'b1;
          nxt_data = rx_ff;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // drive lanes from the next shift value so pins change with the clock edge
  always_comb begin
    lanes = (nxt_state == S_ADDR && quad_a) ? nxt_sh[31:28] : {3'h0, nxt_sh[31]};
    unique case (nxt_state)
      S_CMD: lane_oe = 4'h1;
      S_ADDR: lane_oe = quad_a ? 4'hf : 4'h1;
      default: lane_oe = 4'h0;
    endcase
    nxt_out = {dual ? lanes : 4'h0, lanes} & {dual ? lane_oe : 4'h0, lane_oe};
    nxt_oe = {dual ? lane_oe : 4'h0, lane_oe};
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= 6'h00;
      sh_ff <= 32'h0000_0000;
      rx_ff <= 32'h0000_0000;
      data_ff <= 32'h0000_0000;
      primed_ff <= 1'b0;
      odd_ff <= 1'b1;
      sclk_ff <= 1'b0;
      ssl_b_ff <= 1'b1;
      done_ff <= 1'b0;
      out_ff <= 8'h00;
      oe_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      rx_ff <= nxt_rx;
      data_ff <= nxt_data;
      primed_ff <= nxt_primed;
      odd_ff <= nxt_odd;
      sclk_ff <= nxt_sclk;
      ssl_b_ff <= nxt_ssl_b;
      done_ff <= nxt_done;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
    end
  end

  assign serial_clock_pin_o = sclk_ff;
  assign slave_select_pin_b_o = ssl_b_ff;
  assign io_out_o = out_ff;
  assign io_oe_o = oe_ff;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_idle_clk_low: assert property (
    (slave_select_pin_b_o && !idle_clock_level && !$past(idle_clock_level)) |-> !serial_clock_pin_o)
    else $error("serial clock not low while deselected");
  a_order_dummy: assert property (
    (state_ff == S_DUMMY) |-> ($past(state_ff) inside {S_ADDR, S_DUMMY}))
    else $error("dummy phase not preceded by address");
  a_order_data: assert property (
    (state_ff == S_DATA) |-> ($past(state_ff) inside {S_DUMMY, S_DATA}))
    else $error("data phase not preceded by dummy");
  a_cmd_msb_first: assert property (
    $fell(slave_select_pin_b_o) |-> (io_out_o[0] == read_command_reg_ff[7] && io_oe_o[0]))
    else $error("command msb not presented at select");
  a_tx_even_edge: assert property (
    (!transmit_edge_select && !idle_clock_level && state_ff == S_CMD && $past(state_ff) == S_CMD && $changed(io_out_o))
    |-> $fell(serial_clock_pin_o))
    else $error("output changed off a falling edge");
  a_rx_even_edge: assert property (
    (receive_edge_select && !idle_clock_level && !ddr_d && state_ff == S_DATA && $changed(rx_ff))
    |-> $fell(serial_clock_pin_o))
    else $error("data sampled off a falling edge");
  a_select_held: assert property (
    (state_ff inside {S_CMD, S_ADDR, S_DUMMY, S_DATA}) |-> !slave_select_pin_b_o)
    else $error("select negated mid frame");
  a_dummy_load: assert property (
    (state_ff == S_DUMMY && $past(state_ff) == S_ADDR) |-> (cnt_ff == dummy_cyc - 6'h01))
    else $error("wrong dummy count");
  a_addr_load: assert property (
    (state_ff == S_ADDR && $past(state_ff) == S_CMD) |-> (cnt_ff == addr_slots - 6'h01 &&
      sh_ff[31:24] == (four_b ? read_address_reg_ff[31:24] : read_address_reg_ff[23:16])))
    else $error("wrong address length or first byte");
  a_data_load: assert property (
    (state_ff == S_DATA && $past(state_ff) == S_DUMMY) |-> (cnt_ff == data_samples - 6'h01))
    else $error("wrong data sample count");
endmodule

// >>> sfr_flash_model.sv
module sfr_flash_model (
  // link pins
  input wire logic sclk_i,
  input wire logic sel_b_i,
  input wire logic [3:0] din_i,
  output logic [3:0] dout_o,
  // frame shape and stored word
  input wire logic quad_i,
  input wire logic [5:0] na_i,
  input wire logic [3:0] nd_i,
  input wire logic [31:0] word_i,
  output logic [7:0] cmd_o,
  output logic [31:0] addr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int rc = 0;
  int hdr;
  logic [31:0] sh;
  initial dout_o = 4'h5;
  always_comb hdr = 8 + (quad_i ? na_i / 4 : na_i);
  // frame start clears counters and loads the word to return
  always @(negedge sel_b_i) begin
    rc = 0;
    addr_o = '0;
    sh = word_i;
  end
  // released lanes must not keep the last value
  always @(posedge sel_b_i) dout_o = ~dout_o;
  // incoming bits taken on rising edges only
  always @(posedge sclk_i) if (!sel_b_i) begin
    if (rc < 8) cmd_o = {cmd_o[6:0], din_i[0]};
    else if (rc < hdr) addr_o = quad_i ? {addr_o[27:0], din_i} : {addr_o[30:0], din_i[0]};
    rc = rc + 1;
  end
  // read data moves on falls from the last dummy fall on, else lanes churn
  always @(negedge sclk_i) if (!sel_b_i) begin
    if (rc >= hdr + nd_i) begin
      dout_o = quad_i ? sh[31:28] : {~dout_o[3:2], sh[31], ~dout_o[0]};
      sh = quad_i ? sh << 4 : sh << 1;
    end else dout_o = ~dout_o;
  end
endmodule

// >>> sfr_read_seq_tb_top.sv
module sfr_read_seq_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sfr_pkg::*;
  logic clk_i = 0;
  logic rst_b_i = 0;
  logic [7:0] awaddr = 0, araddr = 0, io_out, io_oe, io_in, cmd;
  // each flash instance drives its own slice, so these are nets
  wire [7:0] m_out;
  wire [15:0] cmds;
  wire [63:0] addrs;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, d, a, cfg;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, r;
  logic bvalid, rvalid, awready, wready, arready, sclk, sel_b, dual;
  logic quad = 1, addr4 = 1;
  logic [3:0] nd = 4;
  logic [63:0] words = 0;
  logic [31:0] seed = 32'h1193;
  logic [7:0] tbl [4] = '{8'h0b, 8'h0c, 8'heb, 8'hec};
  int fails = 0, num_checks = 0, falls = 0, f0, n;
  always #2.5 clk_i = ~clk_i;
  // wire level: driven lanes win, else the flash
  assign io_in = (io_oe & io_out) | (~io_oe & m_out);
  sfr_read_seq #(.HALF(6)) sfr_read_seq_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .serial_clock_pin_o(sclk),
    .slave_select_pin_b_o(sel_b), .io_out_o(io_out), .io_oe_o(io_oe), .io_in_i(io_in));
  // two flashes, device1 on the upper lanes
  sfr_flash_model sfr_flash_model_i [1:0] (.sclk_i(sclk), .sel_b_i(sel_b), .din_i(io_out),
    .dout_o(m_out), .quad_i(quad), .na_i(addr4 ? ADDR4_BITS : ADDR3_BITS), .nd_i(nd),
    .word_i(words), .cmd_o(cmds), .addr_o(addrs));
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait step, a hang ends the run
  task automatic tick(inout int k);
    @(posedge clk_i);
    k++;
    if (k > 300) begin
      fails++;
      summarize();
    end
  endtask
  task automatic wchk(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
    int k = 0;
    @(posedge clk_i);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      tick(k);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    int k = 0;
    @(posedge clk_i);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      tick(k);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] dt;
    logic [1:0] rs;
    rd(ad, dt, rs);
    chk(dt, e);
    chk({30'h0, rs}, {30'h0, er});
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // dual frames interleave the two devices per sample
  function automatic logic [31:0] exp_word(input logic [31:0] x, y, input logic q, dl);
    logic [31:0] e;
    e = x;
    if (dl) for (int i = 0; i < 32; i++) begin
      if (q) e[31-i] = (i % 8 < 4) ? x[31-(i/8)*4-i%8] : y[35-(i/8)*4-i%8];
      else e[31-i] = (i % 2) ? y[31-i/2] : x[31-i/2];
    end
    return e;
  endfunction
  // idle level 0 throughout, so a parked select means a low clock
  always @(posedge clk_i) if (rst_b_i && sel_b === 1'b1) chk({31'h0, sclk}, 32'h0);
  always @(negedge sel_b) falls++;
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rchk(OFS_COMMON, RST_COMMON, RESP_OKAY);
    rchk(OFS_ENABLE, RST_ENABLE, RESP_OKAY);
    rchk(OFS_RATE, RST_RATE, RESP_OKAY);
    rchk(OFS_CMD, RST_CMD, RESP_OKAY);
    rchk(OFS_DUMMY, RST_DUMMY, RESP_OKAY);
    // all rate enables set read back through the mask; the loop restores sdr
    wchk(OFS_RATE, 32'hffff_ffff, RESP_OKAY);
    rchk(OFS_RATE, MSK_RATE, RESP_OKAY);
    rchk(8'h20, 32'h0, RESP_SLVERR);
    wchk(8'h24, 32'h1, RESP_SLVERR);
    for (int i = 0; i < 10; i++) begin
      d = rnd();
      cmd = i < 4 ? tbl[i] : tbl[d[5:4]];
      quad = cmd[7];
      addr4 = cmd[2];
      dual = d[0];
      nd = {1'b0, d[3:1]} + 4'h3;
      a = rnd();
      words = {rnd(), rnd()};
      cfg = {20'h0, addr4 ? 4'hf : 4'h7, 2'h0, {3{quad ? 2'h2 : 2'h0}}};
      // odd-edge sampling also lands mid-bit, so later frames mix both receive edges
      wchk(OFS_COMMON, {27'h0, dual, 1'b0, (i < 4 || d[6]), 2'h0}, RESP_OKAY);
      wchk(OFS_ENABLE, cfg, RESP_OKAY);
      wchk(OFS_RATE, 32'h0, RESP_OKAY);
      wchk(OFS_CMD, {24'h0, cmd}, RESP_OKAY);
      wchk(OFS_DUMMY, {29'h0, d[3:1]}, RESP_OKAY);
      wchk(OFS_ADDR, a, RESP_OKAY);
      rchk(OFS_ENABLE, cfg & MSK_ENABLE, RESP_OKAY);
      f0 = falls;
      wchk(OFS_START, 32'h1, RESP_OKAY);
      if (i == 0) begin
        // while busy a second start and a command change are dropped
        wchk(OFS_START, 32'h1, RESP_OKAY);
        wchk(OFS_CMD, 32'h0, RESP_OKAY);
      end
      n = 0;
      do begin
        rd(OFS_START, d, r);
        n++;
      end while (d[SR_DONE] !== 1'b1 && n < 1000);
      chk(d, 32'h2);
      if (n == 1000) summarize();
      chk(falls - f0, 1);
      chk({24'h0, cmds[7:0]}, {24'h0, cmd});
      chk(addrs[31:0], a & (addr4 ? 32'hffff_ffff : 32'h00ff_ffff));
      rchk(OFS_DATA, exp_word(words[31:0], words[63:32], quad, dual), RESP_OKAY);
      rchk(OFS_CMD, {24'h0, cmd}, RESP_OKAY);
    end
    summarize();
  end
endmodule
